// File: rtl/ecpc_pkg.sv
// Package of the echo canceller path control block.
// Assumes AXI4-Lite access with 32-bit data, one register per aligned word.
package ecpc_pkg;
  // Bus widths
  localparam int ADDR_W = 9;
  localparam int IDX_W = 7;
  // Register indices; the byte address is four times the index
  localparam logic [6:0] IDX_PROTECT = 7'h01;
  localparam logic [6:0] IDX_WDOG_FIRST = 7'h02;
  localparam logic [6:0] IDX_WDOG_SECOND = 7'h03;
  localparam logic [6:0] IDX_WDOG_LAST = 7'h04;
  localparam logic [6:0] IDX_PATH_CTRL = 7'h06;
  localparam logic [6:0] IDX_GLOBAL_OUT = 7'h30;
  localparam logic [6:0] IDX_GLOBAL_LAW = 7'h3f;
  localparam logic [6:0] IDX_CHAN_BASE = 7'h40;
  localparam logic [6:0] IDX_STATUS = 7'h7f;
  // Reset values
  localparam logic [7:0] RST_PROTECT = 8'h00;
  localparam logic [3:0] RST_PATH_CTRL = 4'h0;
  localparam logic [7:0] RST_GLOBAL_OUT = 8'h03;
  localparam logic [3:0] RST_GLOBAL_LAW = 4'h0;
  localparam logic [7:0] RST_CHAN = 8'h00;
  // Keys
  localparam logic [7:0] KEY_UNLOCK = 8'h95;
  localparam logic [7:0] KEY_WDOG_FIRST = 8'haa;
  localparam logic [7:0] KEY_WDOG_SECOND = 8'h99;
  localparam logic [7:0] KEY_WDOG_LAST = 8'h1d;
  // Path control fields
  localparam int PC_SBYP = 0;
  localparam int PC_RBYP = 1;
  localparam int PC_RECEIVE_TO_SEND_LOOP = 2;
  localparam int PC_SEND_TO_RECEIVE_LOOP = 3;
  // Global output fields
  localparam int GO_ERRINV = 0;
  localparam int GO_DYNAMIC_SUBTRACTOR = 1;
  localparam int GO_RLEVEL = 2;
  localparam int GO_RATTEN = 3;
  localparam int GO_SLEVEL = 4;
  localparam int GO_SATTEN = 5;
  localparam int GO_NSHAPE = 6;
  localparam int GO_STDCN = 7;
  // Global law fields
  localparam int GL_FAR = 0;
  localparam int GL_NEAR = 1;
  localparam int GL_DISLAW = 2;
  localparam int GL_CHANNEL_INDIVIDUAL_LAW = 3;
  // Channel control fields
  localparam int CC_EXCL = 0;
  localparam int CC_DIS = 1;
  localparam int CC_NLPOFF = 2;
  localparam int CC_FREEZE = 3;
  localparam int CC_CONVOFF = 4;
  localparam int CC_FAR = 5;
  localparam int CC_NEAR = 6;
  localparam int CC_DISLAW = 7;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Watchdog window
  localparam longint CLK_HZ = 100000000;
  localparam longint WDOG_WINDOW_S = 2;
  localparam longint WDOG_CYCLES = WDOG_WINDOW_S * CLK_HZ;
  localparam int WDOG_W = 28;
  // Watchdog key sequence
  typedef enum logic [1:0] {
    ECPC_WD_IDLE,
    ECPC_WD_GOT1,
    ECPC_WD_GOT2
  } ecpc_wd_t;
endpackage

// File: rtl/ecpc_chan_mem.sv
// Thirty-two channel control words with a registered read port.
// Assumes one write and one read per cycle, both on ref_clk.
`timescale 1ns/1ps
module ecpc_chan_mem (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [32]; // Control words
  logic [7:0] next_mem [32]; // Next control words
  logic [7:0] next_rd_data; // Next read word

  // Write and read selection
  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[wr_addr] = wr_data;
    end
    next_rd_data = mem[rd_addr];
  end

  // Storage, cleared on reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        mem[i] <= ecpc_pkg::RST_CHAN;
      end
      rd_data <= 8'h00;
    end else begin
      mem <= next_mem;
      rd_data <= next_rd_data;
    end
  end
endmodule

// File: rtl/ecpc_top.sv
// Echo canceller path control: registers, loop and bypass muxes,
// per-channel law and canceller control per PCM timeslot.
// Assumes an AXI4-Lite master and a canceller core that returns its
// processed samples in the same cycle as core_valid.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module ecpc_top #(
  parameter logic [27:0] WDOG_LIMIT = 28'(ecpc_pkg::WDOG_CYCLES)
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [8:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [8:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slot_valid,
  input wire logic [4:0] slot_num,
  input wire logic [7:0] rin_data,
  input wire logic [7:0] sin_data,
  input wire logic [7:0] core_rout,
  input wire logic [7:0] core_sout,
  input wire logic ext_conv_off,
  input wire logic ext_freeze,
  input wire logic ext_nlp_off,
  input wire logic ext_disable,
  output logic core_valid,
  output logic [4:0] core_slot,
  output logic [7:0] core_rin,
  output logic [7:0] core_sin,
  output logic out_valid,
  output logic [4:0] out_slot,
  output logic [7:0] rout_data,
  output logic [7:0] sout_data,
  output logic ch_freeze,
  output logic ch_nlp_off,
  output logic ch_disable,
  output logic near_alaw,
  output logic far_alaw,
  output logic send_atten_on,
  output logic send_atten_2p5db,
  output logic recv_atten_on,
  output logic recv_atten_2p5db,
  output logic std_comfort_noise,
  output logic comfort_noise_shape,
  output logic dynamic_subtractor,
  output logic error_sign_invert,
  output logic wdog_alarm
);
  // Bus state
  logic aw_held, next_aw_held; // Write address captured
  logic w_held, next_w_held; // Write data captured
  logic [6:0] aw_idx, next_aw_idx; // Captured write index
  logic [7:0] w_byte, next_w_byte; // Captured low data byte
  logic w_lane0, next_w_lane0; // Low byte lane enabled
  logic bvalid, next_bvalid; // Write response pending
  logic [1:0] bresp, next_bresp; // Write response code
  logic rvalid, next_rvalid; // Read response pending
  logic [1:0] rresp, next_rresp; // Read response code
  logic [31:0] rdata, next_rdata; // Read data
  // Register state
  logic [7:0] protect, next_protect; // Protection key register
  logic [3:0] path_loop_bypass_control, next_path_ctrl;
  logic [7:0] global_output_config, next_global_out;
  logic [3:0] global_law_config, next_global_law;
  // Watchdog state
  ecpc_pkg::ecpc_wd_t wd_state, next_wd_state; // Key sequence step
  logic [27:0] wd_count, next_wd_count; // Cycles since last full key
  logic wd_alarm, next_wd_alarm; // Window missed
  // Write decode
  logic do_write; // Address and data both present
  logic wr_ok; // Write index is mapped
  logic unlocked; // Protected registers may be written
  logic chan_wr; // Channel word write
  logic [6:0] ar_idx; // Read index

  assign do_write = aw_held && w_held && !bvalid;
  assign unlocked = (protect == ecpc_pkg::KEY_UNLOCK);
  assign ar_idx = s_axi_araddr[8:2];
  assign chan_wr = do_write && w_lane0 && unlocked
    && (aw_idx[6:5] == ecpc_pkg::IDX_CHAN_BASE[6:5]);

  // Mapped write indices
  always_comb begin
    case (aw_idx)
      ecpc_pkg::IDX_PROTECT,
      ecpc_pkg::IDX_WDOG_FIRST,
      ecpc_pkg::IDX_WDOG_SECOND,
      ecpc_pkg::IDX_WDOG_LAST,
      ecpc_pkg::IDX_PATH_CTRL,
      ecpc_pkg::IDX_GLOBAL_OUT,
      ecpc_pkg::IDX_GLOBAL_LAW: wr_ok = 1'b1;
      default: wr_ok = (aw_idx[6:5] == ecpc_pkg::IDX_CHAN_BASE[6:5]);
    endcase
  end

  // AXI4-Lite handshakes; address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx = s_axi_awaddr[8:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      // Response follows both halves
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? ecpc_pkg::RESP_OKAY : ecpc_pkg::RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = ecpc_pkg::RESP_OKAY;
      next_rdata = 32'h00000000;
      if (ar_idx == ecpc_pkg::IDX_STATUS) begin
        // Status word shows watchdog and protection state
        next_rdata = {28'h0000000, wd_state, unlocked, wd_alarm};
      end else if (!(ar_idx[6:5] == ecpc_pkg::IDX_CHAN_BASE[6:5])
          && ar_idx != ecpc_pkg::IDX_PROTECT
          && ar_idx != ecpc_pkg::IDX_WDOG_FIRST
          && ar_idx != ecpc_pkg::IDX_WDOG_SECOND
          && ar_idx != ecpc_pkg::IDX_WDOG_LAST
          && ar_idx != ecpc_pkg::IDX_PATH_CTRL
          && ar_idx != ecpc_pkg::IDX_GLOBAL_OUT
          && ar_idx != ecpc_pkg::IDX_GLOBAL_LAW) begin
        // Unmapped address
        next_rresp = ecpc_pkg::RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 7'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= ecpc_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= ecpc_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  // Configuration registers; protected ones need the unlock key
  always_comb begin
    next_protect = protect;
    next_path_ctrl = path_loop_bypass_control;
    next_global_out = global_output_config;
    next_global_law = global_law_config;
    if (do_write && w_lane0) begin
      if (aw_idx == ecpc_pkg::IDX_PROTECT) begin
        next_protect = w_byte;
      end
      if (unlocked) begin
        case (aw_idx)
          ecpc_pkg::IDX_PATH_CTRL: next_path_ctrl = w_byte[3:0];
          ecpc_pkg::IDX_GLOBAL_OUT: next_global_out = w_byte;
          ecpc_pkg::IDX_GLOBAL_LAW: next_global_law = w_byte[3:0];
          default: next_protect = next_protect;
        endcase
      end
    end
  end

  // Configuration storage
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      protect <= ecpc_pkg::RST_PROTECT;
      path_loop_bypass_control <= ecpc_pkg::RST_PATH_CTRL;
      global_output_config <= ecpc_pkg::RST_GLOBAL_OUT;
      global_law_config <= ecpc_pkg::RST_GLOBAL_LAW;
    end else begin
      protect <= next_protect;
      path_loop_bypass_control <= next_path_ctrl;
      global_output_config <= next_global_out;
      global_law_config <= next_global_law;
    end
  end

  // Watchdog: keys in order restart the window; a wrong key restarts
  // the sequence; a missed window raises the alarm
  always_comb begin
    next_wd_state = wd_state;
    next_wd_count = wd_count;
    next_wd_alarm = wd_alarm;
    if (wd_count < WDOG_LIMIT) begin
      next_wd_count = wd_count + 28'h0000001;
    end
    if (do_write && w_lane0) begin
      case (wd_state)
        ecpc_pkg::ECPC_WD_IDLE: begin
          if (aw_idx == ecpc_pkg::IDX_WDOG_FIRST
              && w_byte == ecpc_pkg::KEY_WDOG_FIRST) begin
            next_wd_state = ecpc_pkg::ECPC_WD_GOT1;
          end
        end
        ecpc_pkg::ECPC_WD_GOT1: begin
          if (aw_idx == ecpc_pkg::IDX_WDOG_SECOND
              && w_byte == ecpc_pkg::KEY_WDOG_SECOND) begin
            next_wd_state = ecpc_pkg::ECPC_WD_GOT2;
          end else if (aw_idx >= ecpc_pkg::IDX_WDOG_FIRST
              && aw_idx <= ecpc_pkg::IDX_WDOG_LAST) begin
            next_wd_state = ecpc_pkg::ECPC_WD_IDLE;
          end
        end
        ecpc_pkg::ECPC_WD_GOT2: begin
          if (aw_idx == ecpc_pkg::IDX_WDOG_LAST
              && w_byte == ecpc_pkg::KEY_WDOG_LAST) begin
            next_wd_state = ecpc_pkg::ECPC_WD_IDLE;
            next_wd_count = 28'h0000000;
            next_wd_alarm = 1'b0;
          end else if (aw_idx >= ecpc_pkg::IDX_WDOG_FIRST
              && aw_idx <= ecpc_pkg::IDX_WDOG_LAST) begin
            next_wd_state = ecpc_pkg::ECPC_WD_IDLE;
          end
        end
        default: next_wd_state = ecpc_pkg::ECPC_WD_IDLE;
      endcase
    end
    // Expiry is the one cycle in which the count steps onto the limit,
    // so a saturated count cannot pin the alarm against a key clear;
    // expiry still wins over a clear in the same cycle
    if (wd_count == WDOG_LIMIT - 28'h0000001) begin
      next_wd_alarm = 1'b1;
    end
  end

  // Watchdog storage
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wd_state <= ecpc_pkg::ECPC_WD_IDLE;
      wd_count <= 28'h0000000;
      wd_alarm <= 1'b0;
    end else begin
      wd_state <= next_wd_state;
      wd_count <= next_wd_count;
      wd_alarm <= next_wd_alarm;
    end
  end

  assign wdog_alarm = wd_alarm;

  // Channel control words
  logic [7:0] chan_word; // Word of the slot in stage one
  ecpc_chan_mem u_chan_mem (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .wr_en(chan_wr),
    .wr_addr(aw_idx[4:0]),
    .wr_data(w_byte),
    .rd_addr(slot_num),
    .rd_data(chan_word)
  );

  // Stage one: raw inputs, loops applied toward the canceller core
  logic s1_valid, next_s1_valid; // Slot present in stage one
  logic [4:0] s1_slot, next_s1_slot; // Slot number
  logic [7:0] s1_rin, next_s1_rin; // Raw receive input
  logic [7:0] s1_sin, next_s1_sin; // Raw send input
  logic [7:0] s1_core_rin, next_core_rin; // Core receive input
  logic [7:0] s1_core_sin, next_core_sin; // Core send input
  logic [3:0] s1_ext, next_s1_ext; // External control sources
  logic rs_loop; // Receive-to-send loop active
  logic sr_loop; // Send-to-receive loop active

  assign rs_loop = path_loop_bypass_control[ecpc_pkg::PC_RECEIVE_TO_SEND_LOOP];
  assign sr_loop = path_loop_bypass_control[ecpc_pkg::PC_SEND_TO_RECEIVE_LOOP]
    && !rs_loop;

  always_comb begin
    next_s1_valid = slot_valid;
    next_s1_slot = s1_slot;
    next_s1_rin = s1_rin;
    next_s1_sin = s1_sin;
    next_core_rin = s1_core_rin;
    next_core_sin = s1_core_sin;
    next_s1_ext = s1_ext;
    if (slot_valid) begin
      next_s1_slot = slot_num;
      next_s1_rin = rin_data;
      next_s1_sin = sin_data;
      next_s1_ext = {ext_disable, ext_nlp_off, ext_freeze, ext_conv_off};
      // Loops take the last registered outputs
      next_core_rin = sr_loop ? sout_data : rin_data;
      next_core_sin = rs_loop ? rout_data : sin_data;
    end
  end

  // Stage two: bypass muxes and per-channel controls
  logic [7:0] next_rout, next_sout; // Next line outputs
  logic next_out_valid; // Next output strobe
  logic [4:0] next_out_slot; // Next output slot
  logic [4:0] next_ctrl; // Freeze, nlp off, disable, near, far
  logic excl; // Only register bits control the channel
  logic conv_off, dis_eff, channel_individual_law, law_dis; // Derived controls

  always_comb begin
    excl = chan_word[ecpc_pkg::CC_EXCL];
    channel_individual_law = global_law_config[ecpc_pkg::GL_CHANNEL_INDIVIDUAL_LAW];
    conv_off = chan_word[ecpc_pkg::CC_CONVOFF]
      || (!excl && s1_ext[0]);
    dis_eff = chan_word[ecpc_pkg::CC_DIS]
      || (!excl && s1_ext[3]);
    next_ctrl[4] = chan_word[ecpc_pkg::CC_FREEZE]
      || (!excl && s1_ext[1]);
    next_ctrl[3] = chan_word[ecpc_pkg::CC_NLPOFF]
      || (!excl && s1_ext[2]);
    next_ctrl[2] = dis_eff;
    if (channel_individual_law) begin
      // Channel law bits apply
      law_dis = chan_word[ecpc_pkg::CC_DISLAW];
      next_ctrl[1] = chan_word[ecpc_pkg::CC_NEAR];
      next_ctrl[0] = chan_word[ecpc_pkg::CC_FAR];
    end else begin
      // Global law bits apply
      law_dis = global_law_config[ecpc_pkg::GL_DISLAW];
      next_ctrl[1] = global_law_config[ecpc_pkg::GL_NEAR];
      next_ctrl[0] = global_law_config[ecpc_pkg::GL_FAR];
    end
    if (conv_off) begin
      // No conversion: both sides in the disabled law
      next_ctrl[1] = law_dis;
      next_ctrl[0] = law_dis;
    end
    next_out_valid = s1_valid;
    next_out_slot = s1_valid ? s1_slot : out_slot;
    next_rout = rout_data;
    next_sout = sout_data;
    if (s1_valid) begin
      next_rout = path_loop_bypass_control[ecpc_pkg::PC_RBYP]
        ? s1_rin : core_rout;
      next_sout = path_loop_bypass_control[ecpc_pkg::PC_SBYP]
        ? s1_sin : core_sout;
    end
  end

  // Pipeline registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s1_valid <= 1'b0;
      s1_slot <= 5'h00;
      s1_rin <= 8'h00;
      s1_sin <= 8'h00;
      s1_core_rin <= 8'h00;
      s1_core_sin <= 8'h00;
      s1_ext <= 4'h0;
      out_valid <= 1'b0;
      out_slot <= 5'h00;
      rout_data <= 8'h00;
      sout_data <= 8'h00;
      {ch_freeze, ch_nlp_off, ch_disable, near_alaw, far_alaw} <= 5'h00;
    end else begin
      s1_valid <= next_s1_valid;
      s1_slot <= next_s1_slot;
      s1_rin <= next_s1_rin;
      s1_sin <= next_s1_sin;
      s1_core_rin <= next_core_rin;
      s1_core_sin <= next_core_sin;
      s1_ext <= next_s1_ext;
      out_valid <= next_out_valid;
      out_slot <= next_out_slot;
      rout_data <= next_rout;
      sout_data <= next_sout;
      if (s1_valid) begin
        {ch_freeze, ch_nlp_off, ch_disable, near_alaw, far_alaw}
          <= next_ctrl;
      end
    end
  end

  assign core_valid = s1_valid;
  assign core_slot = s1_slot;
  assign core_rin = s1_core_rin;
  assign core_sin = s1_core_sin;

  // Attenuators act only while the channel's canceller is enabled
  assign send_atten_on = global_output_config[ecpc_pkg::GO_SATTEN]
    && !ch_disable;
  assign send_atten_2p5db =
    global_output_config[ecpc_pkg::GO_SLEVEL];
  assign recv_atten_on = global_output_config[ecpc_pkg::GO_RATTEN]
    && !ch_disable;
  assign recv_atten_2p5db =
    global_output_config[ecpc_pkg::GO_RLEVEL];
  // Shape matters only with standard comfort noise
  assign std_comfort_noise = global_output_config[ecpc_pkg::GO_STDCN];
  assign comfort_noise_shape = global_output_config[ecpc_pkg::GO_NSHAPE]
    && global_output_config[ecpc_pkg::GO_STDCN];
  assign dynamic_subtractor =
    global_output_config[ecpc_pkg::GO_DYNAMIC_SUBTRACTOR];
  assign error_sign_invert =
    global_output_config[ecpc_pkg::GO_ERRINV];
endmodule

// File: verification/ecpc_top_checker.sv
// Concurrent checks on the path control block's top ports.
// Assumes binding onto ecpc_top, one clock, sync active-low reset.
`timescale 1ns/1ps
module ecpc_top_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic slot_valid,
  input wire logic core_valid,
  input wire logic out_valid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_arready,
  input wire logic ch_disable,
  input wire logic send_atten_on,
  input wire logic recv_atten_on,
  input wire logic std_comfort_noise,
  input wire logic comfort_noise_shape,
  input wire logic error_sign_invert
);
  // Reset masks every check
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // A slot passes the core stage, then the output stage
  sequence s_path;
    core_valid ##1 out_valid;
  endsequence
  a_slot_path: assert property (slot_valid |=> s_path)
    else $error("slot did not reach output in two cycles");
  a_core_quiet: assert property (!slot_valid |=> !core_valid)
    else $error("core strobe without a slot");
  a_noise_shape: assert property (
    comfort_noise_shape |-> std_comfort_noise)
    else $error("noise shape without standard noise");
  a_satt_off: assert property (ch_disable |-> !send_atten_on)
    else $error("send attenuation on a disabled channel");
  a_ratt_off: assert property (ch_disable |-> !recv_atten_on)
    else $error("receive attenuation on a disabled channel");
  a_reset_sign: assert property (
    $rose(reset_n) |-> error_sign_invert)
    else $error("error sign not inverted after reset");
  a_b_idle: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule
bind ecpc_top ecpc_top_checker u_chk (.*);

// File: verification/ecpc_core_model.sv
// Canceller core model on the far side of the stream port.
// Assumes results are sampled in the cycle core_valid is high.
`timescale 1ns/1ps
module ecpc_core_model (
  input wire logic core_valid,
  input wire logic [7:0] core_rin,
  input wire logic [7:0] core_sin,
  output logic [7:0] core_rout,
  output logic [7:0] core_sout
);
  // Fixed scrambles stand for cancelling; idle lines show the inverse
  assign core_rout = core_valid ? core_rin ^ 8'h5a : ~core_rin;
  assign core_sout = core_valid ? core_sin ^ 8'ha5 : ~core_sin;
endmodule

// File: verification/ecpc_tb.sv
// Self-checking bench for the path control block.
// Assumes AXI4-Lite master tasks, core model and shortened watchdog.
`timescale 1ns/1ps
module echo_canceller_path_control_tb_top;
  logic ref_clk = 0, reset_n = 0;
  logic [8:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h54db2b93, rdat;
  logic [3:0] s_axi_wstrb, pc = 0, ext, g, ex;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, slot_valid, core_valid, out_valid;
  logic ext_conv_off, ext_freeze, ext_nlp_off, ext_disable, dis;
  logic [4:0] slot_num, core_slot, out_slot, ch;
  logic [7:0] rin_data, sin_data, core_rout, core_sout, core_rin;
  logic [7:0] core_sin, rout_data, sout_data, er = 0, es = 0, cfg, w;
  logic ch_freeze, ch_nlp_off, ch_disable, near_alaw, far_alaw;
  logic send_atten_on, send_atten_2p5db, recv_atten_on, recv_atten_2p5db;
  logic std_comfort_noise, comfort_noise_shape, dynamic_subtractor;
  logic error_sign_invert, wdog_alarm;
  int n_fail = 0, n_checks = 0, cyc = 0;
  ecpc_top #(.WDOG_LIMIT(28'd100)) dut (.*);
  ecpc_core_model core (.*);
  always #5 ref_clk = ~ref_clk;
  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected {near, far} law; conversion off forces the disabled law
  function automatic logic [1:0] law(input logic [3:0] gl,
    input logic [7:0] wd, input logic cv);
    logic dl;
    dl = gl[3] ? wd[7] : gl[2];
    if (cv) return {dl, dl};
    return gl[3] ? wd[6:5] : gl[1:0];
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Write one register; each half released once taken
  task wr(input logic [6:0] i, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge ref_clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    tb = 0;
    while (!tb) begin
      @(negedge ref_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    #1;
  endtask
  task rd(input logic [6:0] i);
    logic ta, tr;
    @(posedge ref_clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    tr = 0;
    while (!tr) begin
      @(negedge ref_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    #1;
  endtask
  // One timeslot with random samples, outputs checked two edges on
  task slot(input logic [4:0] c);
    logic [7:0] r, s, cr, cs;
    r = 8'(rnd());
    s = 8'(rnd());
    cr = (pc[3] && !pc[2]) ? es : r;
    cs = pc[2] ? er : s;
    er = pc[1] ? r : cr ^ 8'h5a;
    es = pc[0] ? s : cs ^ 8'ha5;
    @(posedge ref_clk);
    slot_valid <= 1;
    slot_num <= c;
    rin_data <= r;
    sin_data <= s;
    {ext_conv_off, ext_freeze, ext_nlp_off, ext_disable} <= ext;
    @(posedge ref_clk);
    slot_valid <= 0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(out_slot, c);
    chk(rout_data, er);
    chk(sout_data, es);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, slot_valid} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, slot_num, rin_data, sin_data, ext} = '0;
    {ext_conv_off, ext_freeze, ext_nlp_off, ext_disable} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    #1;
    chk(error_sign_invert, 1);
    chk(dynamic_subtractor, 1);
    repeat (110) @(posedge ref_clk);
    chk(wdog_alarm, 1);
    wr(7'h02, 8'haa);
    wr(7'h03, 8'h99);
    wr(7'h04, 8'h1d);
    chk(wdog_alarm, 0);
    wr(7'h06, 8'h02);
    chk(resp, ecpc_pkg::RESP_OKAY);
    slot(5'h03);
    rd(7'h06);
    chk(rdat, 0);
    rd(7'h7e);
    chk(resp, ecpc_pkg::RESP_SLVERR);
    wr(7'h7e, 8'h00);
    chk(resp, ecpc_pkg::RESP_SLVERR);
    wr(7'h01, 8'h95);
    rd(7'h7f);
    chk(rdat, 32'h00000002);
    for (int i = 0; i < 16; i++) begin
      pc = 4'(i);
      wr(7'h06, {4'h0, pc});
      repeat (2) slot(5'(rnd()));
    end
    for (int i = 0; i < 6; i++) begin
      cfg = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'(rnd());
      wr(7'h30, cfg);
      chk(std_comfort_noise, cfg[7]);
      chk(comfort_noise_shape, cfg[7] & cfg[6]);
      chk(send_atten_2p5db, cfg[4]);
      chk(recv_atten_2p5db, cfg[2]);
      chk(dynamic_subtractor, cfg[1]);
      chk(error_sign_invert, cfg[0]);
    end
    cfg = 8'h2b;
    wr(7'h30, cfg);
    repeat (40) begin
      g = 4'(rnd());
      w = 8'(rnd());
      ext = 4'(rnd());
      ch = 5'(rnd());
      wr(7'h3f, {4'h0, g});
      wr({2'b10, ch}, w);
      slot(ch);
      ex = w[0] ? 4'h0 : ext;
      dis = w[1] | ex[0];
      chk({near_alaw, far_alaw}, law(g, w, w[4] | ex[3]));
      chk(ch_freeze, w[3] | ex[2]);
      chk(ch_nlp_off, w[2] | ex[1]);
      chk(ch_disable, dis);
      chk(send_atten_on, cfg[5] & !dis);
      chk(recv_atten_on, cfg[3] & !dis);
    end
    summarize();
  end
endmodule
